// ==== shared/hie_cfg.svh ====
// constants for the low half of the interrupt event register
`ifndef HIE_CFG_SVH
`define HIE_CFG_SVH
`define HIE_OFF_SET 8'h80
`define HIE_OFF_CLR 8'h84
`define HIE_B_CYCLE 20
`define HIE_B_PHY 19
`define HIE_B_TOPO 17
`define HIE_B_NODE_ID 16
`define HIE_B_LOCK 9
`define HIE_B_BUF_WR 8
`define HIE_B_RX_SUM 7
`define HIE_B_TX_SUM 6
`define HIE_B_RSP_PKT 5
`define HIE_B_REQ_PKT 4
`define HIE_B_RX_RSP_DMA 3
`define HIE_B_RX_REQ_DMA 2
`define HIE_B_RSP_TX 1
`define HIE_B_REQ_TX 0
`define HIE_LATCH_MASK 21'h1b033f
`define HIE_RSVD_MASK 21'h04fc00
`define HIE_EVT_RESET 21'h000000
`define HIE_ISO_RESET 2'h0
`define HIE_RD_RESET 32'h00000000
`define HIE_UPPER_ZERO 11'h000
`endif

// ==== shared/hie_pkg.sv ====
// types for the low half of the interrupt event register
package hie_pkg;
  typedef logic [20:0] hie_evt_t;
  typedef logic [31:0] hie_word_t;
  typedef logic [7:0] hie_addr_t;
endpackage

// ==== rtl/hie_event_low.sv ====
// interrupt event register, bits 20 to 0, with set/clear access
//
// Notes on behaviour
// - cycle-start bit sets whenever the cycle counter low bit toggles.
// - phy request bit sets on a phy status-transfer interrupt request.
// - bits 18 and 15 to 10 always read zero, writes ignored.
// - topology-reset bit sets when phy reports entering bus reset.
// - node-id-done bit sets when self-id stream fully received.
// - node-id-done bit clears in the cycle topology-reset bit sets.
// - lock reply error bit sets when lock reply got no ack_complete.
// - buffered write error bit sets on host bus error storing write.
// - receive summary is unlatched OR of context events and masks.
// - transmit summary is unlatched OR of context events and masks.
// - response packet bit sets after packet stored, descriptor updated.
// - request packet bit sets after packet stored, descriptor updated.
// - receive response dma bit sets on qualified descriptor done.
// - receive request dma bit sets on qualified descriptor done.
// - response transmit done bit sets on qualified command done.
// - request transmit done bit sets on qualified command done.
// - rising source edge (toggle for cycle start) or set write sets; clear write clears, and topology reset also clears node-id-done.
// - reads return event bits ANDed with the interrupt mask.
`timescale 1ns/1ps
`include "hie_cfg.svh"

module hie_event_low
  import hie_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire hie_addr_t reg_addr,
  input wire hie_word_t reg_wdata,
  output hie_word_t reg_rdata,
  output logic reg_rvalid,
  // mask register contents
  input wire hie_word_t mask_flags,
  // link layer sources
  input wire logic cycle_count_lsb,
  input wire logic phy_status_irq,
  input wire logic phy_bus_reset,
  input wire logic self_id_received,
  input wire logic lock_reply_unacked,
  input wire logic buffered_write_bus_err,
  // asynchronous dma sources
  input wire logic response_packet_stored,
  input wire logic request_packet_stored,
  input wire logic async_receive_response_context,
  input wire logic async_receive_request_context,
  input wire logic async_transmit_response_context,
  input wire logic async_transmit_request_context,
  // isochronous per-context event and mask
  input wire hie_word_t iso_rx_events,
  input wire hie_word_t iso_rx_masks,
  input wire hie_word_t iso_tx_events,
  input wire hie_word_t iso_tx_masks,
  // raw state view
  output hie_evt_t event_flags
);

  function automatic logic addr_hit(hie_addr_t a, hie_addr_t off);
    addr_hit = (a == off);
  endfunction

  hie_evt_t src;
  hie_evt_t src_prev_r;
  hie_evt_t src_prev_nxt;
  hie_evt_t edge_det;
  hie_evt_t evt_r;
  hie_evt_t evt_nxt;
  hie_evt_t set_v;
  hie_evt_t clr_v;
  hie_evt_t view;
  logic [1:0] iso_r;
  logic [1:0] iso_nxt;
  hie_word_t rdata_r;
  hie_word_t rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic wr_set;
  logic wr_clr;
  logic rd_hit;

  // gather sources at their bit positions
  always_comb begin
    src = `HIE_EVT_RESET;
    src[`HIE_B_CYCLE] = cycle_count_lsb;
    src[`HIE_B_PHY] = phy_status_irq;
    src[`HIE_B_TOPO] = phy_bus_reset;
    src[`HIE_B_NODE_ID] = self_id_received;
    src[`HIE_B_LOCK] = lock_reply_unacked;
    src[`HIE_B_BUF_WR] = buffered_write_bus_err;
    src[`HIE_B_RSP_PKT] = response_packet_stored;
    src[`HIE_B_REQ_PKT] = request_packet_stored;
    src[`HIE_B_RX_RSP_DMA] = async_receive_response_context;
    src[`HIE_B_RX_REQ_DMA] = async_receive_request_context;
    src[`HIE_B_RSP_TX] = async_transmit_response_context;
    src[`HIE_B_REQ_TX] = async_transmit_request_context;
  end

  // edge detection: toggle for cycle start, rising edge elsewhere
  genvar gi;
  generate
    for (gi = 0; gi < 21; gi++) begin : g_edge
      if (gi == `HIE_B_CYCLE) begin : g_tog
        assign edge_det[gi] = src[gi] ^ src_prev_r[gi];
      end else begin : g_rise
        assign edge_det[gi] = src[gi] & ~src_prev_r[gi];
      end
    end
  endgenerate

  always_comb begin
    src_prev_nxt = src;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      src_prev_r <= `HIE_EVT_RESET;
    end else begin
      src_prev_r <= src_prev_nxt;
    end
  end

  assign wr_set = reg_wr & addr_hit(reg_addr, `HIE_OFF_SET);
  assign wr_clr = reg_wr & addr_hit(reg_addr, `HIE_OFF_CLR);
  assign rd_hit = reg_rd & (addr_hit(reg_addr, `HIE_OFF_SET) |
                            addr_hit(reg_addr, `HIE_OFF_CLR));

  // latched events: set beats clear in the same cycle
  always_comb begin
    set_v = edge_det | (wr_set ? reg_wdata[20:0] : `HIE_EVT_RESET);
    clr_v = wr_clr ? reg_wdata[20:0] : `HIE_EVT_RESET;
    evt_nxt = (evt_r & ~clr_v) | set_v;
    if (evt_nxt[`HIE_B_TOPO] && !evt_r[`HIE_B_TOPO]) begin
      evt_nxt[`HIE_B_NODE_ID] = 1'b0;
    end
    // summary and reserved positions never latch
    evt_nxt = evt_nxt & `HIE_LATCH_MASK;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_r <= `HIE_EVT_RESET;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // isochronous summaries follow their contexts
  always_comb begin
    iso_nxt = {|(iso_rx_events & iso_rx_masks),
               |(iso_tx_events & iso_tx_masks)};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      iso_r <= `HIE_ISO_RESET;
    end else begin
      iso_r <= iso_nxt;
    end
  end

  always_comb begin
    view = evt_r;
    view[`HIE_B_RX_SUM] = iso_r[1];
    view[`HIE_B_TX_SUM] = iso_r[0];
  end

  // read path: masked view, zero elsewhere
  always_comb begin
    rvalid_nxt = reg_rd;
    rdata_nxt = `HIE_RD_RESET;
    if (rd_hit) begin
      rdata_nxt = {`HIE_UPPER_ZERO, view & mask_flags[20:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r <= `HIE_RD_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign event_flags = view;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cycle_toggle;
    $changed(cycle_count_lsb) |=> event_flags[`HIE_B_CYCLE];
  endproperty
  a_cycle_toggle: assert property (p_cycle_toggle)
    else $error("cycle start not latched on toggle");

  property p_phy_rise;
    $rose(phy_status_irq) |=> event_flags[`HIE_B_PHY];
  endproperty
  a_phy_rise: assert property (p_phy_rise)
    else $error("phy request not latched");

  property p_reserved_zero;
    (event_flags & `HIE_RSVD_MASK) == `HIE_EVT_RESET &&
      reg_rdata[31:21] == `HIE_UPPER_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit nonzero");

  property p_topo_rise;
    $rose(phy_bus_reset) |=> event_flags[`HIE_B_TOPO];
  endproperty
  a_topo_rise: assert property (p_topo_rise)
    else $error("topology reset not latched");

  sequence s_topo_sets;
    !event_flags[`HIE_B_TOPO] ##1 event_flags[`HIE_B_TOPO];
  endsequence
  property p_topo_kills_id;
    s_topo_sets |-> !event_flags[`HIE_B_NODE_ID];
  endproperty
  a_topo_kills_id: assert property (p_topo_kills_id)
    else $error("node id done survived topology reset");

  property p_id_rise;
    $rose(self_id_received) && !$rose(phy_bus_reset) &&
      !(wr_set && reg_wdata[`HIE_B_TOPO])
      |=> event_flags[`HIE_B_NODE_ID];
  endproperty
  a_id_rise: assert property (p_id_rise)
    else $error("node id done not latched");

  property p_dma_rise;
    $rose(async_transmit_request_context) |=>
      event_flags[`HIE_B_REQ_TX];
  endproperty
  a_dma_rise: assert property (p_dma_rise)
    else $error("request transmit done not latched");

  property p_hold;
    event_flags[`HIE_B_LOCK] && !(wr_clr && reg_wdata[`HIE_B_LOCK])
      |=> event_flags[`HIE_B_LOCK];
  endproperty
  a_hold: assert property (p_hold)
    else $error("event dropped without clear write");

  property p_set_beats_clear;
    wr_clr && reg_wdata[`HIE_B_BUF_WR] && $rose(buffered_write_bus_err)
      |=> event_flags[`HIE_B_BUF_WR];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("event lost to simultaneous clear");

  property p_rx_sum;
    |(iso_rx_events & iso_rx_masks) |=> event_flags[`HIE_B_RX_SUM];
  endproperty
  a_rx_sum: assert property (p_rx_sum)
    else $error("receive summary missing");

  property p_tx_sum;
    !(|(iso_tx_events & iso_tx_masks)) |=> !event_flags[`HIE_B_TX_SUM];
  endproperty
  a_tx_sum: assert property (p_tx_sum)
    else $error("transmit summary latched");

  property p_read_masked;
    rd_hit |=> reg_rvalid &&
      reg_rdata[20:0] == ($past(view) & $past(mask_flags[20:0]));
  endproperty
  a_read_masked: assert property (p_read_masked)
    else $error("read not masked view");

  property p_lock_rise;
    $rose(lock_reply_unacked) |=> event_flags[`HIE_B_LOCK];
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock reply error not latched");

  property p_rsp_pkt_rise;
    $rose(response_packet_stored) |=> event_flags[`HIE_B_RSP_PKT];
  endproperty
  a_rsp_pkt_rise: assert property (p_rsp_pkt_rise)
    else $error("response packet stored not latched");

  property p_req_pkt_rise;
    $rose(request_packet_stored) |=> event_flags[`HIE_B_REQ_PKT];
  endproperty
  a_req_pkt_rise: assert property (p_req_pkt_rise)
    else $error("request packet stored not latched");

  property p_rx_rsp_rise;
    $rose(async_receive_response_context) |=>
      event_flags[`HIE_B_RX_RSP_DMA];
  endproperty
  a_rx_rsp_rise: assert property (p_rx_rsp_rise)
    else $error("receive response dma not latched");

  property p_rx_req_rise;
    $rose(async_receive_request_context) |=>
      event_flags[`HIE_B_RX_REQ_DMA];
  endproperty
  a_rx_req_rise: assert property (p_rx_req_rise)
    else $error("receive request dma not latched");

  property p_rsp_tx_rise;
    $rose(async_transmit_response_context) |=>
      event_flags[`HIE_B_RSP_TX];
  endproperty
  a_rsp_tx_rise: assert property (p_rsp_tx_rise)
    else $error("response transmit done not latched");

endmodule // hie_event_low

// ==== verification/hie_src_model.sv ====
// source side model: link and dma event sources
`timescale 1ns/1ps
module hie_src_model (
  // clock
  input wire logic clk,
  // event sources
  output logic [10:0] srcs,
  output logic cyc
);
  initial begin
    srcs = 11'h000;
    cyc = 1'b0;
  end
  // one-cycle request on source i, raised whenever the testbench calls it
  task automatic pulse(input int i);
    srcs[i] = 1'b1;
    @(negedge clk);
    srcs[i] = 1'b0;
  endtask
  // cycle counter low bit flips once
  task automatic toggle();
    cyc = ~cyc;
    @(negedge clk);
  endtask
endmodule // hie_src_model

// ==== verification/hie_event_low_tb_top.sv ====
// testbench for the low half of the interrupt event register
`timescale 1ns/1ps
`include "hie_cfg.svh"
module hie_event_low_tb_top;
  import hie_pkg::*;
  logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, cyc;
  hie_addr_t reg_addr;
  hie_word_t reg_wdata, reg_rdata, mask_flags;
  hie_word_t rx_ev, rx_mk, tx_ev, tx_mk;
  logic [10:0] srcs;
  hie_evt_t event_flags;
  int fails, n_checks;
  int pos[11] = '{19, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0};
  hie_src_model src (.clk(clk), .srcs(srcs), .cyc(cyc));
  hie_event_low dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mask_flags(mask_flags), .cycle_count_lsb(cyc),
    .phy_status_irq(srcs[0]), .phy_bus_reset(srcs[1]),
    .self_id_received(srcs[2]), .lock_reply_unacked(srcs[3]),
    .buffered_write_bus_err(srcs[4]), .response_packet_stored(srcs[5]),
    .request_packet_stored(srcs[6]),
    .async_receive_response_context(srcs[7]),
    .async_receive_request_context(srcs[8]),
    .async_transmit_response_context(srcs[9]),
    .async_transmit_request_context(srcs[10]),
    .iso_rx_events(rx_ev), .iso_rx_masks(rx_mk),
    .iso_tx_events(tx_ev), .iso_tx_masks(tx_mk),
    .event_flags(event_flags));
  task automatic check(input string nm, input hie_word_t seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic flags(input hie_word_t exp);
    check("event_flags", {11'h000, event_flags}, exp);
    check("reg_rvalid", {31'h0, reg_rvalid}, 32'h0);
    check("reg_rdata", reg_rdata, 32'h0);
  endtask
  task automatic wr(input hie_addr_t a, input hie_word_t d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input hie_addr_t a, input hie_word_t exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    check("reg_rvalid", {31'h0, reg_rvalid}, 32'h1);
    check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    mask_flags = 32'hffffffff;
    rx_ev = 32'h0;
    rx_mk = 32'h0;
    tx_ev = 32'h0;
    tx_mk = 32'h0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    flags(32'h0);
    foreach (pos[i]) begin
      src.pulse(i);
      flags(32'h1 << pos[i]);
      rd(`HIE_OFF_CLR, 32'h1 << pos[i]);
      wr(`HIE_OFF_CLR, 32'h1 << pos[i]);
      flags(32'h0);
    end
    @(negedge clk);
    fork
      src.pulse(4);
      wr(`HIE_OFF_CLR, 32'h100);
    join
    flags(32'h100);
    @(negedge clk);
    wr(`HIE_OFF_CLR, 32'h100);
    flags(32'h0);
    repeat (2) begin
      src.toggle();
      flags(32'h1 << 20);
      wr(`HIE_OFF_CLR, 32'h1 << 20);
    end
    @(negedge clk);
    wr(`HIE_OFF_SET, 32'h1 << 16);
    flags(32'h1 << 16);
    src.pulse(1);
    flags(32'h1 << 17);
    wr(`HIE_OFF_SET, 32'hffffffff);
    flags({11'h000, `HIE_LATCH_MASK});
    mask_flags = 32'h00000f0f;
    rd(`HIE_OFF_SET, 32'h0000030f);
    @(negedge clk);
    rd(8'h88, 32'h0);
    wr(`HIE_OFF_CLR, 32'hffffffff);
    flags(32'h0);
    mask_flags = 32'hffffffff;
    rx_ev = 32'h20;
    @(negedge clk);
    flags(32'h0);
    rx_mk = 32'h20;
    @(negedge clk);
    flags(32'h80);
    wr(`HIE_OFF_CLR, 32'hc0);
    flags(32'h80);
    rx_ev = 32'h0;
    tx_ev = 32'h4;
    tx_mk = 32'h6;
    @(negedge clk);
    flags(32'h40);
    rd(`HIE_OFF_SET, 32'h40);
    tx_ev = 32'h0;
    @(negedge clk);
    flags(32'h0);
    report_and_stop();
  end
endmodule // hie_event_low_tb_top
